// File: adc_conversion_sequencer.sv
// Functional notes
// - Control A write starts conversion if powered up
// - Start while busy aborts and restarts
// - Control B and C writes never start
// - Channel code selects sixteen inputs, 14-15 internal
// - Differential: channel non-inverting, field picks inverting
// - Resolution gives 6, 8, 10 or 12 bits
// - Single mode converts once; continuous repeats
// - Busy rises four 16 MHz cycles after start
// - Busy falls when result bytes are written
// - Done interrupt at end of every conversion
// - After single step, power down or standby delay
// - Auto power-down leaves power-up bit unchanged
// - Wakeup 15 us from off, 0.6 us standby
// - Phases wakeup, acquisition, conversion in order
// - Acquisition 0.75, 3, 12 or 36 us
// - Conversion 1.7 to 2.3 us by resolution
// - Continuous restarts at 2-16 ksps rate
// - Continuous powers down between conversions
// - Single-ended results are straight binary
// - Differential results are offset binary
// - Under, over and their OR status bits
// - Control A layout: pwrup, busy, chsel, refsel
// - Single mode rate: 0, 6, 24 us, forever
// - Continuous rate codes 2-16 ksps, top reserved
// - Resolution codes and justification bit
`timescale 1ns/1ps
module adc_conversion_sequencer #(
  parameter int unsigned ACQ3_CYC = adc_seq_pkg::ACQ3_CYC,
  parameter int unsigned PDD2_CYC = adc_seq_pkg::PDD2_CYC,
  parameter int unsigned PER0_CYC = adc_seq_pkg::PER0_CYC,
  parameter int unsigned PER1_CYC = adc_seq_pkg::PER1_CYC,
  parameter int unsigned PER2_CYC = adc_seq_pkg::PER2_CYC,
  parameter int unsigned PER3_CYC = adc_seq_pkg::PER3_CYC,
  parameter int          TIMER_W  = adc_seq_pkg::TIMER_W
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // Interrupt request to the core
  output logic             conversion_done_irq_o,
  // Analog front end control
  output logic      [3:0]  afe_channel_o,
  output logic             afe_internal_src_o,
  output logic      [1:0]  afe_reference_o,
  output logic      [1:0]  afe_diff_mode_o,
  output logic      [1:0]  afe_resolution_o,
  output logic             analog_pin_enable_o,
  output logic             afe_power_o,
  output logic             afe_standby_o,
  output logic             afe_sample_connect_o,
  output logic             afe_convert_o,
  // Analog front end result
  input  wire logic [11:0] afe_result_i
);

  typedef struct packed {
    adc_seq_pkg::seq_state_t state;
    logic                    busy;
    logic                    short_wake;
    logic                    stby_forever;
    logic                    pwrup;
    logic [3:0]              chsel;
    logic [1:0]              refsel;
    logic [7:0]              ctrl_b;
    logic [1:0]              resol;
    logic                    rjust;
    logic                    uflow;
    logic                    oflow;
    logic [7:0]              res_hi;
    logic [7:0]              res_lo;
    logic [7:0]              rdata;
    logic                    irq;
    logic [TIMER_W-1:0]      period;
  } seq_regs_t;

  seq_regs_t state_reg;
  seq_regs_t state_next;

  phase_timer_if #(.W(TIMER_W)) tif ();

  logic               tmr_load;
  logic [TIMER_W-1:0] tmr_value;
  logic               start;
  logic [11:0]        code;
  logic [11:0]        mask;
  logic [15:0]        packed_res;

  // Control B fields
  logic [1:0] diffm;
  logic       cont;
  logic [2:0] rate;
  logic [1:0] tacq;

  assign diffm = state_reg.ctrl_b[adc_seq_pkg::B_DIFF_LSB +: 2];
  assign cont  = state_reg.ctrl_b[adc_seq_pkg::B_CONT_BIT];
  assign rate  = state_reg.ctrl_b[adc_seq_pkg::B_RATE_LSB +: 3];
  assign tacq  = state_reg.ctrl_b[adc_seq_pkg::B_TACQ_LSB +: 2];

  // Acquisition length in cycles
  function automatic logic [TIMER_W-1:0] acq_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    acq_cycles = TIMER_W'(adc_seq_pkg::ACQ0_CYC);
      2'h1:    acq_cycles = TIMER_W'(adc_seq_pkg::ACQ1_CYC);
      2'h2:    acq_cycles = TIMER_W'(adc_seq_pkg::ACQ2_CYC);
      default: acq_cycles = TIMER_W'(ACQ3_CYC);
    endcase
  endfunction

  // Conversion phase length by resolution
  function automatic logic [TIMER_W-1:0] conv_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    conv_cycles = TIMER_W'(adc_seq_pkg::CONV0_CYC);
      2'h1:    conv_cycles = TIMER_W'(adc_seq_pkg::CONV1_CYC);
      2'h2:    conv_cycles = TIMER_W'(adc_seq_pkg::CONV2_CYC);
      default: conv_cycles = TIMER_W'(adc_seq_pkg::CONV3_CYC);
    endcase
  endfunction

  // Sample period; reserved codes fall back to the slowest rate
  function automatic logic [TIMER_W-1:0] period_cycles(input logic [2:0] sel);
    case (sel)
      3'h1:    period_cycles = TIMER_W'(PER1_CYC);
      3'h2:    period_cycles = TIMER_W'(PER2_CYC);
      3'h3:    period_cycles = TIMER_W'(PER3_CYC);
      default: period_cycles = TIMER_W'(PER0_CYC);
    endcase
  endfunction

  // Mask keeping the top result bits of the chosen resolution
  function automatic logic [11:0] res_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    res_mask = 12'hFC0;
      2'h1:    res_mask = 12'hFF0;
      2'h2:    res_mask = 12'hFFC;
      default: res_mask = 12'hFFF;
    endcase
  endfunction

  // Output coding: front end gives unsigned single-ended, signed differential
  always_comb begin
    if (diffm == 2'h0) begin
      code = afe_result_i;
    end else begin
      code = {~afe_result_i[11], afe_result_i[10:0]};
    end
    mask = res_mask(state_reg.resol);
    code = code & mask;
    if (state_reg.rjust) begin
      case (state_reg.resol)
        2'h0:    packed_res = {10'h000, code[11:6]};
        2'h1:    packed_res = {8'h00, code[11:4]};
        2'h2:    packed_res = {6'h00, code[11:2]};
        default: packed_res = {4'h0, code};
      endcase
    end else begin
      packed_res = {code, 4'h0};
    end
  end

  assign start = wr_i && (addr_i == adc_seq_pkg::ADDR_CTRL_A)
               && wdata_i[adc_seq_pkg::A_PWRUP_BIT];

  // Next state: register writes, phase sequence, restart
  always_comb begin
    state_next = state_reg;
    state_next.rdata = 8'h00;
    state_next.irq = 1'b0;
    tmr_load = 1'b0;
    tmr_value = '0;
    if (state_reg.period != '0) begin
      state_next.period = state_reg.period - TIMER_W'(1);
    end

    // Register writes; B and C only store settings
    if (wr_i) begin
      case (addr_i)
        adc_seq_pkg::ADDR_CTRL_A: begin
          state_next.pwrup  = wdata_i[adc_seq_pkg::A_PWRUP_BIT];
          state_next.chsel  = wdata_i[adc_seq_pkg::A_CHSEL_LSB +: 4];
          state_next.refsel = wdata_i[adc_seq_pkg::A_REFSEL_LSB +: 2];
        end
        adc_seq_pkg::ADDR_CTRL_B: begin
          state_next.ctrl_b = wdata_i;
        end
        adc_seq_pkg::ADDR_CTRL_C: begin
          state_next.resol = wdata_i[adc_seq_pkg::C_RESOL_LSB +: 2];
          state_next.rjust = wdata_i[adc_seq_pkg::C_RJUST_BIT];
        end
        default: begin
        end
      endcase
    end

    // Phase sequencing
    case (state_reg.state)
      adc_seq_pkg::ST_IDLE: begin
      end
      adc_seq_pkg::ST_ARM: begin
        if (tif.done) begin
          state_next.busy  = 1'b1;
          state_next.state = adc_seq_pkg::ST_WAKE;
          tmr_load = 1'b1;
          tmr_value = state_reg.short_wake ? TIMER_W'(adc_seq_pkg::WUP_SB_CYC)
                                           : TIMER_W'(adc_seq_pkg::WUP_PD_CYC);
        end
      end
      adc_seq_pkg::ST_WAKE: begin
        if (tif.done) begin
          state_next.state = adc_seq_pkg::ST_ACQ;
          tmr_load = 1'b1;
          tmr_value = acq_cycles(tacq);
        end
      end
      adc_seq_pkg::ST_ACQ: begin
        if (tif.done) begin
          state_next.state = adc_seq_pkg::ST_CONV;
          tmr_load = 1'b1;
          tmr_value = conv_cycles(state_reg.resol);
        end
      end
      adc_seq_pkg::ST_CONV: begin
        if (tif.done) begin
          state_next.res_hi = packed_res[15:8];
          state_next.res_lo = packed_res[7:0];
          state_next.uflow  = (code == 12'h000);
          state_next.oflow  = (code == mask);
          state_next.busy   = 1'b0;
          state_next.irq    = 1'b1;
          state_next.stby_forever = 1'b0;
          if (cont) begin
            state_next.state = adc_seq_pkg::ST_PAUSE;
          end else begin
            case (rate)
              3'h1: begin
                state_next.state = adc_seq_pkg::ST_STBY;
                tmr_load = 1'b1;
                tmr_value = TIMER_W'(adc_seq_pkg::PDD1_CYC);
              end
              3'h2: begin
                state_next.state = adc_seq_pkg::ST_STBY;
                tmr_load = 1'b1;
                tmr_value = TIMER_W'(PDD2_CYC);
              end
              3'h3: begin
                state_next.state = adc_seq_pkg::ST_STBY;
                state_next.stby_forever = 1'b1;
              end
              default: begin
                state_next.state = adc_seq_pkg::ST_IDLE;
              end
            endcase
          end
        end
      end
      adc_seq_pkg::ST_STBY: begin
        if (!state_reg.stby_forever && tif.done) begin
          state_next.state = adc_seq_pkg::ST_IDLE;
        end
      end
      adc_seq_pkg::ST_PAUSE: begin
        if (!cont) begin
          state_next.state = adc_seq_pkg::ST_IDLE;
        end else if (state_reg.period == '0) begin
          state_next.state = adc_seq_pkg::ST_ARM;
          state_next.short_wake = 1'b0;
          state_next.period = period_cycles(rate) - TIMER_W'(1);
          tmr_load = 1'b1;
          tmr_value = TIMER_W'(adc_seq_pkg::BUSY_CYC);
        end
      end
      default: begin
        state_next.state = adc_seq_pkg::ST_IDLE;
      end
    endcase

    // Start write overrides everything, aborting a running conversion
    if (start) begin
      state_next.state = adc_seq_pkg::ST_ARM;
      state_next.short_wake = (state_reg.state == adc_seq_pkg::ST_STBY);
      // Period counts down to zero, so it is loaded one short
      state_next.period = period_cycles(rate) - TIMER_W'(1);
      state_next.irq = 1'b0;
      state_next.busy = state_reg.busy;
      tmr_load = 1'b1;
      tmr_value = TIMER_W'(adc_seq_pkg::BUSY_CYC);
      if (state_reg.state == adc_seq_pkg::ST_CONV) begin
        state_next.res_hi = state_reg.res_hi;
        state_next.res_lo = state_reg.res_lo;
        state_next.uflow  = state_reg.uflow;
        state_next.oflow  = state_reg.oflow;
      end
    end else if (!state_next.pwrup) begin
      // Software power-down ends any activity
      state_next.state = adc_seq_pkg::ST_IDLE;
      state_next.busy  = 1'b0;
    end

    // Register reads, data in the following cycle
    if (rd_i) begin
      case (addr_i)
        adc_seq_pkg::ADDR_CTRL_A: state_next.rdata = {state_reg.pwrup, state_reg.busy,
                                                      state_reg.chsel, state_reg.refsel};
        adc_seq_pkg::ADDR_CTRL_B: state_next.rdata = state_reg.ctrl_b;
        adc_seq_pkg::ADDR_CTRL_C: state_next.rdata = {state_reg.resol, state_reg.rjust,
                                                      state_reg.uflow, state_reg.oflow,
                                                      state_reg.uflow | state_reg.oflow,
                                                      2'h0};
        adc_seq_pkg::ADDR_RES_HI: state_next.rdata = state_reg.res_hi;
        adc_seq_pkg::ADDR_RES_LO: state_next.rdata = state_reg.res_lo;
        default:                  state_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Phase timer
  assign tif.load  = tmr_load;
  assign tif.value = tmr_value;

  phase_timer #(
    .W (TIMER_W)
  ) u_timer (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .tif       (tif.timer)
  );

  // Outputs
  assign rdata_o               = state_reg.rdata;
  assign conversion_done_irq_o = state_reg.irq;
  assign afe_channel_o         = state_reg.chsel;
  assign afe_internal_src_o    = (state_reg.chsel >= 4'hE);
  assign afe_reference_o       = state_reg.refsel;
  assign afe_diff_mode_o       = diffm;
  assign afe_resolution_o      = state_reg.resol;
  assign analog_pin_enable_o   = state_reg.pwrup;

  // Analog power and phase controls decoded from the state
  assign afe_power_o = (state_reg.state == adc_seq_pkg::ST_WAKE)
                    || (state_reg.state == adc_seq_pkg::ST_ACQ)
                    || (state_reg.state == adc_seq_pkg::ST_CONV);
  assign afe_standby_o        = (state_reg.state == adc_seq_pkg::ST_STBY);
  assign afe_sample_connect_o = (state_reg.state == adc_seq_pkg::ST_ACQ);
  assign afe_convert_o        = (state_reg.state == adc_seq_pkg::ST_CONV);

endmodule

// File: adc_seq_pkg.sv
package adc_seq_pkg;

  // Clock rate and cycle conversion
  localparam int CLK_MHZ = 250;
  localparam int TIMER_W = 17;

  // Register addresses
  localparam logic [7:0] ADDR_CTRL_A  = 8'hD3;
  localparam logic [7:0] ADDR_CTRL_B  = 8'hD2;
  localparam logic [7:0] ADDR_CTRL_C  = 8'hD1;
  localparam logic [7:0] ADDR_RES_HI  = 8'hD4;
  localparam logic [7:0] ADDR_RES_LO  = 8'hD5;
  localparam logic [7:0] REG_RESET    = 8'h00;

  // Control A fields
  localparam int A_PWRUP_BIT = 7;
  localparam int A_BUSY_BIT  = 6;
  localparam int A_CHSEL_LSB = 2;
  localparam int A_REFSEL_LSB = 0;
  // Control B fields
  localparam int B_DIFF_LSB  = 6;
  localparam int B_CONT_BIT  = 5;
  localparam int B_RATE_LSB  = 2;
  localparam int B_TACQ_LSB  = 0;
  // Control C fields
  localparam int C_RESOL_LSB = 6;
  localparam int C_RJUST_BIT = 5;
  localparam int C_UFLOW_BIT = 4;
  localparam int C_OFLOW_BIT = 3;
  localparam int C_RANGE_BIT = 2;

  // Phase times in ns
  localparam int T_BUSY_NS    = 250;
  localparam int T_WUP_SB_NS  = 600;
  localparam int T_WUP_PD_NS  = 15000;
  localparam int T_ACQ0_NS    = 750;
  localparam int T_ACQ1_NS    = 3000;
  localparam int T_ACQ2_NS    = 12000;
  localparam int T_ACQ3_NS    = 36000;
  localparam int T_CONV0_NS   = 1700;
  localparam int T_CONV1_NS   = 1900;
  localparam int T_CONV2_NS   = 2100;
  localparam int T_CONV3_NS   = 2300;
  localparam int T_PDD1_NS    = 6000;
  localparam int T_PDD2_NS    = 24000;
  localparam int T_PER0_NS    = 500000;
  localparam int T_PER1_NS    = 250000;
  localparam int T_PER2_NS    = 125000;
  localparam int T_PER3_NS    = 62500;

  // Least times rounded up to whole clock cycles
  localparam int BUSY_CYC   = (T_BUSY_NS * CLK_MHZ + 999) / 1000;
  localparam int WUP_SB_CYC = (T_WUP_SB_NS * CLK_MHZ + 999) / 1000;
  localparam int WUP_PD_CYC = (T_WUP_PD_NS * CLK_MHZ + 999) / 1000;
  localparam int ACQ0_CYC   = (T_ACQ0_NS * CLK_MHZ + 999) / 1000;
  localparam int ACQ1_CYC   = (T_ACQ1_NS * CLK_MHZ + 999) / 1000;
  localparam int ACQ2_CYC   = (T_ACQ2_NS * CLK_MHZ + 999) / 1000;
  localparam int ACQ3_CYC   = (T_ACQ3_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV0_CYC  = (T_CONV0_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV1_CYC  = (T_CONV1_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV2_CYC  = (T_CONV2_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV3_CYC  = (T_CONV3_NS * CLK_MHZ + 999) / 1000;
  localparam int PDD1_CYC   = (T_PDD1_NS * CLK_MHZ + 999) / 1000;
  localparam int PDD2_CYC   = (T_PDD2_NS * CLK_MHZ + 999) / 1000;
  localparam int PER0_CYC   = (T_PER0_NS * CLK_MHZ + 999) / 1000;
  localparam int PER1_CYC   = (T_PER1_NS * CLK_MHZ + 999) / 1000;
  localparam int PER2_CYC   = (T_PER2_NS * CLK_MHZ + 999) / 1000;
  localparam int PER3_CYC   = (T_PER3_NS * CLK_MHZ + 999) / 1000;

  // Sequencer states, Gray along idle-arm-wake-acq-conv-standby
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ARM   = 3'h1,
    ST_WAKE  = 3'h3,
    ST_ACQ   = 3'h2,
    ST_CONV  = 3'h6,
    ST_STBY  = 3'h7,
    ST_PAUSE = 3'h5
  } seq_state_t;

endpackage

// File: phase_timer_if.sv
`timescale 1ns/1ps
interface phase_timer_if #(
  parameter int W = 17
);
  logic         load;
  logic [W-1:0] value;
  logic         done;

  modport seq   (output load, output value, input done);
  modport timer (input load, input value, output done);
endinterface

// File: phase_timer.sv
`timescale 1ns/1ps
module phase_timer #(
  parameter int W = 17
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // Sequencer side
  phase_timer_if.timer tif
);

  typedef struct packed {
    logic [W-1:0] count;
  } timer_state_t;

  timer_state_t state_reg;
  timer_state_t state_next;

  // Load N gives done in the Nth cycle after the load
  always_comb begin
    state_next = state_reg;
    if (tif.load) begin
      state_next.count = tif.value;
    end else if (state_reg.count != '0) begin
      state_next.count = state_reg.count - W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Done in the last cycle of the count; kept off the load path so no loop forms
  assign tif.done = (state_reg.count == W'(1));

endmodule

// File: adc_seq_checker.sv
`timescale 1ns/1ps
module adc_seq_checker (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // Register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] rdata_o,
  // Front end side
  input  wire logic       conversion_done_irq_o,
  input  wire logic [3:0] afe_channel_o,
  input  wire logic       afe_internal_src_o,
  input  wire logic       analog_pin_enable_o,
  input  wire logic       afe_power_o,
  input  wire logic       afe_standby_o,
  input  wire logic       afe_sample_connect_o,
  input  wire logic       afe_convert_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  logic       a_wr;
  logic       armed_reg;
  logic [6:0] since_reg;

  // Write strobe aimed at control A
  assign a_wr = wr_i && (addr_i == adc_seq_pkg::ADDR_CTRL_A);

  // Cycles since the last control A write, saturating
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      armed_reg <= 1'b0;
      since_reg <= 7'h00;
    end else if (a_wr) begin
      armed_reg <= wdata_i[7];
      since_reg <= 7'h01;
    end else if (since_reg != 7'h7F) begin
      since_reg <= since_reg + 7'h01;
    end
  end

  chk_arm_quiet: assert property (armed_reg && since_reg == 7'h3F |-> !afe_power_o)
    else $error("front end powered before the start delay ran out");
  chk_wake_begun: assert property (armed_reg && since_reg == 7'h40 |->
    afe_power_o && !afe_sample_connect_o)
    else $error("wakeup phase not running after the start delay");
  chk_start_quiet: assert property (a_wr && wdata_i[7] |=>
    (!afe_power_o && !conversion_done_irq_o) [*8])
    else $error("start write did not abandon the running conversion");
  chk_irq_pulse: assert property (conversion_done_irq_o |=> !conversion_done_irq_o)
    else $error("done request longer than one cycle");
  chk_irq_from_conv: assert property ($rose(conversion_done_irq_o) |-> $past(afe_convert_o))
    else $error("done request without a conversion phase before it");
  chk_acq_after_wake: assert property ($rose(afe_sample_connect_o) |->
    $past(afe_power_o) && !afe_convert_o)
    else $error("acquisition began without wakeup");
  chk_conv_after_acq: assert property ($rose(afe_convert_o) |-> $past(afe_sample_connect_o))
    else $error("conversion began without acquisition");
  chk_acq_hold: assert property ($rose(afe_sample_connect_o) |-> afe_sample_connect_o [*8])
    else $error("acquisition window too short");
  chk_phase_excl: assert property (
    $onehot0({afe_standby_o, afe_sample_connect_o, afe_convert_o}))
    else $error("two phases active at once");
  chk_pins_follow: assert property (a_wr |=> analog_pin_enable_o == $past(wdata_i[7]))
    else $error("analog pin enable differs from power-up bit");
  chk_power_off: assert property (!analog_pin_enable_o |=> !afe_power_o && !afe_standby_o)
    else $error("front end active with power-up bit clear");
  chk_internal_src: assert property (afe_internal_src_o == (afe_channel_o[3:1] == 3'h7))
    else $error("internal source decode wrong");
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");

  // Main scenarios reached
  cover property (conversion_done_irq_o);
  cover property ($rose(afe_standby_o));
  cover property ($fell(afe_standby_o) && !afe_power_o);
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb;
  localparam int PER3 = 5000;
  localparam int PER0 = 8000;
  logic        clk_i        = 1'b0;
  logic        reset_n_i    = 1'b0;
  logic [7:0]  addr_i       = 8'h00;
  logic [7:0]  wdata_i      = 8'h00;
  logic        wr_i         = 1'b0;
  logic        rd_i         = 1'b0;
  logic [11:0] afe_result_i = 12'h000;
  logic [7:0]  rdata_o;
  logic        irq;
  logic [3:0]  chan;
  logic [1:0]  refs;
  logic [1:0]  diffm;
  logic [1:0]  resol;
  logic        stby_o;
  logic        power_o;
  logic        rd_d         = 1'b0;
  logic        stby         = 1'b0;
  logic [31:0] seed         = 32'h3E9D;
  logic [7:0]  expq[$];
  int          ticks        = 0;
  int          failures     = 0;
  int          n_checks     = 0;
  int          t1;

  adc_conversion_sequencer #(.ACQ3_CYC(300), .PDD2_CYC(400), .PER0_CYC(PER0),
    .PER1_CYC(7000), .PER2_CYC(6000), .PER3_CYC(PER3)) adc_conversion_sequencer_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .conversion_done_irq_o(irq),
    .afe_channel_o(chan), .afe_internal_src_o(), .afe_reference_o(refs),
    .afe_diff_mode_o(diffm), .afe_resolution_o(resol), .analog_pin_enable_o(),
    .afe_power_o(power_o), .afe_standby_o(stby_o), .afe_sample_connect_o(),
    .afe_convert_o(), .afe_result_i(afe_result_i));

  // Clock and cycle count
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) ticks <= ticks + 1;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic int cyc(input int ns);
    return (ns * 250 + 999) / 1000;
  endfunction

  task automatic end_sim();
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    n_checks++;
    if (got < exp - 1 || got > exp + 3) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    expq.push_back(e);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (irq !== 1'b1 && n < 60000);
    if (irq !== 1'b1) begin
      failures++;
      end_sim();
    end
  endtask

  task automatic no_irq(input int len);
    logic seen;
    seen = 1'b0;
    repeat (len) begin
      @(posedge clk_i);
      if (irq === 1'b1) seen = 1'b1;
    end
    cmp({7'h00, seen}, 8'h00);
  endtask

  // One single-step conversion with result, flags and timing checked
  task automatic run(input logic [1:0] rs, input logic rj, input logic [1:0] dm,
                     input logic [1:0] tq, input logic [2:0] rt, input logic [11:0] v);
    logic [11:0] m;
    logic [11:0] c;
    logic [15:0] r;
    logic [7:0]  a;
    int          e;
    int          t0;
    seed = xs(seed);
    a = {2'b10, seed[5:0]};
    m = 12'hFFF >> (6 - 2 * rs);
    c = ((dm != 2'h0) ? {~v[11], v[10:0]} : v) >> (6 - 2 * rs);
    r = rj ? {4'h0, c} : ({c, 4'h0} << (6 - 2 * rs));
    e = cyc(250) + (stby ? cyc(600) : cyc(15000)) + cyc(1700 + 200 * rs);
    e = e + ((tq == 2'h3) ? 300 : cyc(tq == 2'h0 ? 750 : tq == 2'h1 ? 3000 : 12000));
    afe_result_i <= v;
    wr(adc_seq_pkg::ADDR_CTRL_B, {dm, 1'b0, rt, tq});
    wr(adc_seq_pkg::ADDR_CTRL_C, {rs, rj, 5'h1F});
    repeat (70) @(posedge clk_i);
    cmp({7'h00, power_o}, 8'h00);
    wr(adc_seq_pkg::ADDR_CTRL_A, a);
    t0 = ticks;
    rd(adc_seq_pkg::ADDR_CTRL_A, a);
    repeat (70) @(posedge clk_i);
    rd(adc_seq_pkg::ADDR_CTRL_A, a | 8'h40);
    wait_irq();
    chk_n(ticks - t0, e);
    rd(adc_seq_pkg::ADDR_CTRL_A, a);
    rd(adc_seq_pkg::ADDR_CTRL_C, {rs, rj, !c, c == m, !c || c == m, 2'h0});
    rd(adc_seq_pkg::ADDR_RES_HI, r[15:8]);
    rd(adc_seq_pkg::ADDR_RES_LO, r[7:0]);
    cmp({4'h0, resol, diffm}, {4'h0, rs, dm});
    cmp({2'h0, chan, refs}, {2'h0, a[5:0]});
    stby = (rt == 3'h1 || rt == 3'h2 || rt == 3'h3);
    cmp({7'h00, stby_o}, {7'h00, stby});
    if (rt == 3'h2) begin
      repeat (420) @(posedge clk_i);
      stby = 1'b0;
      cmp({7'h00, stby_o}, 8'h00);
    end
  endtask

  // Read answers compared against the oldest note
  always @(posedge clk_i) begin
    if (rd_d) cmp(rdata_o, expq.pop_front());
    rd_d <= rd_i;
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 6; i++) rd(8'hD0 + i[7:0], 8'h00);
    wr(adc_seq_pkg::ADDR_RES_HI, 8'hAA);
    wr(adc_seq_pkg::ADDR_CTRL_C, 8'hFF);
    rd(adc_seq_pkg::ADDR_RES_HI, 8'h00);
    rd(adc_seq_pkg::ADDR_CTRL_C, 8'hE0);
    run(2'h3, 1'b0, 2'h0, 2'h0, 3'h1, seed[11:0]);
    run(2'h3, 1'b1, 2'h1, 2'h3, 3'h2, seed[27:16]);
    run(2'h3, 1'b0, 2'h2, 2'h1, 3'h3, seed[23:12]);
    run(2'h0, 1'b0, 2'h0, 2'h2, 3'h4, 12'hFFF);
    run(2'h1, 1'b1, 2'h0, 2'h0, 3'h0, 12'h000);
    run(2'h2, 1'b0, 2'h0, 2'h0, 3'h0, 12'hFFF);
    // Restart in mid-sequence, only the second start completes
    wr(adc_seq_pkg::ADDR_CTRL_A, 8'h80);
    repeat (20) @(posedge clk_i);
    wr(adc_seq_pkg::ADDR_CTRL_A, 8'h84);
    t1 = ticks;
    wait_irq();
    chk_n(ticks - t1, cyc(250) + cyc(15000) + cyc(750) + cyc(2100));
    no_irq(200);
    // Power-up cleared mid-run and start without power-up
    wr(adc_seq_pkg::ADDR_CTRL_A, 8'h80);
    repeat (200) @(posedge clk_i);
    wr(adc_seq_pkg::ADDR_CTRL_A, 8'h3C);
    no_irq(5000);
    rd(adc_seq_pkg::ADDR_CTRL_A, 8'h3C);
    // Continuous mode at the fastest and the slowest rate
    for (int k = 0; k < 2; k++) begin
      wr(adc_seq_pkg::ADDR_CTRL_B, k ? 8'h20 : 8'h2C);
      wr(adc_seq_pkg::ADDR_CTRL_A, 8'h80);
      wait_irq();
      t1 = ticks;
      wait_irq();
      chk_n(ticks - t1, k ? PER0 : PER3);
      repeat (5) @(posedge clk_i);
      cmp({7'h00, power_o}, 8'h00);
      wr(adc_seq_pkg::ADDR_CTRL_A, 8'h00);
    end
    repeat (4) @(posedge clk_i);
    end_sim();
  end
endmodule

bind adc_conversion_sequencer adc_seq_checker adc_seq_checker_i (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .conversion_done_irq_o(conversion_done_irq_o), .afe_channel_o(afe_channel_o),
  .afe_internal_src_o(afe_internal_src_o), .analog_pin_enable_o(analog_pin_enable_o),
  .afe_power_o(afe_power_o), .afe_standby_o(afe_standby_o),
  .afe_sample_connect_o(afe_sample_connect_o), .afe_convert_o(afe_convert_o));
